/* lsr_top.sv */
// Light sensor bus slave, register file and conversion control
// Summary of operation
// - Eight byte registers, six implemented; command and control hold until rewritten.
// - Slave address is 100010 plus the address-select pin as bit 0.
// - After start, first seven bits compare to own address; eighth is R/W.
// - The receiving side pulls data low in the acknowledge slot.
// - Four read-only data bytes: two light count, two cycle count.
// - Data bytes hold latest converter result and, in external mode, previous period's cycles.
// - Register address bit 7 set restarts integration, external mode only.
// - Register address bit 6 set clears the pending interrupt.
// - Command bit 7 low holds converter in reset; high enables it.
// - Command bit 6 high powers the device down; low is normal.
// - Command bit 5 picks internal count timing or host timing.
// - External period spans two consecutive restart commands from host.
// - Command bits 3:2: 00,01 disable, 10 light count, 11 no operation.
// - Light count is signed n-1 bits, n being 4, 8, 12 or 16.
// - Command bits 1:0 give 65536, 4096, 256 or 16 cycles.
// - Internal period comes from the oscillator and the n-bit counter.
// - Control bits 3:2 select lux range one to four.
// - Light count bytes refresh at the end of every integration; cycle count bytes only in external mode.
// - External mode counts oscillator cycles and latches them each period.
// - Lower address holds the low byte, next address the high byte.
`timescale 1ns/10ps
module lsr_top (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	input wire logic addr_select_pin_in,
	input wire logic osc_clk_in,
	input wire logic [15:0] light_sample_in,
	output logic converter_core_on_out,
	output logic sleep_request_out,
	output logic [1:0] lux_range_out,
	output logic int_clear_out,
	output logic conv_done_out
);
	lsr_pkg::lsr_line_ev_t ev;
	lsr_pkg::lsr_state_t state_reg;
	lsr_pkg::lsr_state_t after_ack_reg;
	lsr_pkg::lsr_cmd_t cmd_reg;
	logic [7:0] ctrl_reg;
	logic [7:0] ptr_reg;
	logic [7:0] shift_reg;
	logic [7:0] tx_reg;
	logic [2:0] bit_cnt_reg;
	logic ack_pend_reg;
	logic mack_ok_reg;
	logic sync_reg;
	logic addr_sel;
	logic [6:0] own_addr;
	logic [7:0] rx_byte;
	logic byte_end;
	logic addr_hit;
	logic reg_fire;
	logic wr_fire;
	logic wr_cmd;
	logic wr_ctrl;
	logic [7:0] rd_data;
	logic [15:0] light_count;
	logic [15:0] cycle_count;

	lsr_line_sync u_sync (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.addr_select_pin_in(addr_select_pin_in),
		.ev_out(ev),
		.addr_select_out(addr_sel)
	);

	lsr_integrator u_integ (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.osc_clk_in(osc_clk_in),
		.cmd_in(cmd_reg),
		.sync_in(sync_reg),
		.light_sample_in(light_sample_in),
		.light_count_out(light_count),
		.cycle_count_out(cycle_count),
		.done_out(conv_done_out)
	);

	assign own_addr = {lsr_pkg::ADDR_HI, addr_sel};
	assign rx_byte = {shift_reg[6:0], ev.sda};
	assign byte_end = ev.scl_rise && (bit_cnt_reg == 3'h7);
	assign addr_hit = (rx_byte[7:1] == own_addr);
	assign reg_fire = byte_end && (state_reg == lsr_pkg::ST_REG);
	assign wr_fire = byte_end && (state_reg == lsr_pkg::ST_WR);
	// Special addresses carry commands, not register writes
	assign wr_cmd = wr_fire && (ptr_reg == lsr_pkg::OFF_CMD);
	assign wr_ctrl = wr_fire && (ptr_reg == lsr_pkg::OFF_CTRL);

	// Unmapped and threshold addresses read as zero
	always_comb begin
		unique case (ptr_reg)
			lsr_pkg::OFF_CMD: rd_data = cmd_reg;
			lsr_pkg::OFF_CTRL: rd_data = ctrl_reg;
			lsr_pkg::OFF_LIGHT_LO: rd_data = light_count[7:0];
			lsr_pkg::OFF_LIGHT_HI: rd_data = light_count[15:8];
			lsr_pkg::OFF_CYC_LO: rd_data = cycle_count[7:0];
			lsr_pkg::OFF_CYC_HI: rd_data = cycle_count[15:8];
			default: rd_data = 8'h00;
		endcase
	end

	// Byte-level protocol engine
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_reg <= lsr_pkg::ST_IDLE;
			after_ack_reg <= lsr_pkg::ST_IDLE;
			shift_reg <= 8'h00;
			tx_reg <= 8'h00;
			bit_cnt_reg <= 3'h0;
			ack_pend_reg <= 1'b0;
			mack_ok_reg <= 1'b0;
			sda_oe_out <= 1'b0;
		end else if (ev.start) begin
			// Repeated start keeps the pointer for a read
			state_reg <= lsr_pkg::ST_DEV;
			bit_cnt_reg <= 3'h0;
			ack_pend_reg <= 1'b0;
			sda_oe_out <= 1'b0;
		end else if (ev.stop) begin
			state_reg <= lsr_pkg::ST_IDLE;
			ack_pend_reg <= 1'b0;
			sda_oe_out <= 1'b0;
		end else if (ev.scl_rise) begin
			unique case (state_reg)
				lsr_pkg::ST_DEV, lsr_pkg::ST_REG, lsr_pkg::ST_WR: begin
					shift_reg <= rx_byte;
					bit_cnt_reg <= bit_cnt_reg + 3'h1;
					if (bit_cnt_reg == 3'h7) begin
						if (state_reg != lsr_pkg::ST_DEV) begin
							ack_pend_reg <= 1'b1;
							after_ack_reg <= lsr_pkg::ST_WR;
						end else if (addr_hit) begin
							ack_pend_reg <= 1'b1;
							after_ack_reg <= rx_byte[0] ?
								lsr_pkg::ST_RD : lsr_pkg::ST_REG;
						end else begin
							state_reg <= lsr_pkg::ST_IDLE;
						end
					end
				end
				lsr_pkg::ST_RD: bit_cnt_reg <= bit_cnt_reg + 3'h1;
				lsr_pkg::ST_MACK: mack_ok_reg <= !ev.sda;
				lsr_pkg::ST_IDLE, lsr_pkg::ST_ACK: begin
				end
			endcase
		end else if (ev.scl_fall) begin
			if (ack_pend_reg) begin
				// Pull data low through the acknowledge slot
				ack_pend_reg <= 1'b0;
				sda_oe_out <= 1'b1;
				state_reg <= lsr_pkg::ST_ACK;
			end else begin
				unique case (state_reg)
					lsr_pkg::ST_ACK: begin
						state_reg <= after_ack_reg;
						bit_cnt_reg <= 3'h0;
						tx_reg <= rd_data;
						sda_oe_out <= (after_ack_reg == lsr_pkg::ST_RD) &&
							!rd_data[7];
					end
					lsr_pkg::ST_RD: begin
						if (bit_cnt_reg == 3'h0) begin
							sda_oe_out <= 1'b0;
							state_reg <= lsr_pkg::ST_MACK;
						end else begin
							sda_oe_out <= !tx_reg[3'h7 - bit_cnt_reg];
						end
					end
					lsr_pkg::ST_MACK: begin
						// Master ack asks for the same register again
						if (mack_ok_reg) begin
							state_reg <= lsr_pkg::ST_RD;
							bit_cnt_reg <= 3'h0;
							tx_reg <= rd_data;
							sda_oe_out <= !rd_data[7];
						end else begin
							state_reg <= lsr_pkg::ST_IDLE;
						end
					end
					lsr_pkg::ST_IDLE, lsr_pkg::ST_DEV, lsr_pkg::ST_REG,
					lsr_pkg::ST_WR: begin
					end
				endcase
			end
		end
	end

	// Open drain: the pad only ever pulls low
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			sda_out <= 1'b0;
		else
			sda_out <= 1'b0;
	end

	// Register pointer and special-address commands
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ptr_reg <= lsr_pkg::OFF_CMD;
			sync_reg <= 1'b0;
			int_clear_out <= 1'b0;
		end else begin
			if (reg_fire)
				ptr_reg <= rx_byte;
			// Restart only makes sense when the host times the period
			sync_reg <= reg_fire && rx_byte[lsr_pkg::BIT_SYNC] &&
				cmd_reg.timing_ext;
			int_clear_out <= reg_fire && rx_byte[lsr_pkg::BIT_CLR];
		end
	end

	// Writable registers; data bytes have no write path
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cmd_reg <= lsr_pkg::RST_CMD;
			ctrl_reg <= lsr_pkg::RST_CTRL;
		end else begin
			if (wr_cmd)
				cmd_reg <= rx_byte;
			if (wr_ctrl)
				ctrl_reg <= rx_byte & 8'h0C;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			converter_core_on_out <= 1'b0;
			sleep_request_out <= 1'b0;
			lux_range_out <= 2'h0;
		end else begin
			converter_core_on_out <= cmd_reg.core_on;
			sleep_request_out <= cmd_reg.sleep;
			lux_range_out <=
				ctrl_reg[lsr_pkg::CTRL_RANGE_LSB +: 2];
		end
	end

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	a_cmd_hold: assert property (!wr_cmd |=> $stable(cmd_reg))
		else $error("command register changed without a write");
	a_addr_fixed: assert property ((byte_end && !ev.start &&
		!ev.stop && state_reg == lsr_pkg::ST_DEV &&
		rx_byte[7:2] != 6'h22) |=> !ack_pend_reg &&
		state_reg == lsr_pkg::ST_IDLE)
		else $error("address with wrong upper bits accepted");
	a_addr_miss: assert property ((byte_end && !addr_hit &&
		state_reg == lsr_pkg::ST_DEV && !ev.start && !ev.stop)
		|=> state_reg == lsr_pkg::ST_IDLE)
		else $error("foreign address not ignored");
	a_ack_drive: assert property ((ack_pend_reg && ev.scl_fall &&
		!ev.start && !ev.stop) |=> sda_oe_out &&
		state_reg == lsr_pkg::ST_ACK)
		else $error("acknowledge not driven");
	a_ro_data: assert property ((wr_fire && ptr_reg[2]) |=>
		conv_done_out || ($stable(light_count) && $stable(cycle_count)))
		else $error("data register changed by a write");
	a_sync_fire: assert property ((reg_fire && rx_byte[7] &&
		cmd_reg.timing_ext) |=> sync_reg ##1 !sync_reg)
		else $error("restart command lost");
	a_sync_int: assert property ((reg_fire && rx_byte[7] &&
		!cmd_reg.timing_ext) |=> !sync_reg)
		else $error("restart acted in internal mode");
	a_clear_int: assert property ((reg_fire && rx_byte[6]) |=>
		int_clear_out ##1 !int_clear_out)
		else $error("interrupt clear pulse wrong");
	a_range_out: assert property (wr_ctrl |=> ##1
		lux_range_out == $past(rx_byte[3:2], 2))
		else $error("range output does not follow control");
	a_sleep_out: assert property (wr_cmd |=> ##1
		sleep_request_out == $past(rx_byte[6], 2))
		else $error("power-down output does not follow command");

	c_read: cover property (state_reg == lsr_pkg::ST_MACK &&
		ev.scl_fall);
	c_write: cover property (wr_cmd);
	c_sync: cover property (sync_reg);
	c_done: cover property (conv_done_out);

endmodule : lsr_top

/* lsr_pkg.sv */
// Shared constants and types for the light sensor register port
package lsr_pkg;

	// Register offsets
	localparam logic [7:0] OFF_CMD = 8'h00;
	localparam logic [7:0] OFF_CTRL = 8'h01;
	localparam logic [7:0] OFF_LIGHT_LO = 8'h04;
	localparam logic [7:0] OFF_LIGHT_HI = 8'h05;
	localparam logic [7:0] OFF_CYC_LO = 8'h06;
	localparam logic [7:0] OFF_CYC_HI = 8'h07;

	// Values after reset
	localparam logic [7:0] RST_CMD = 8'h00;
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [15:0] RST_DATA = 16'h0000;

	// Fixed upper six bits of the slave address
	localparam logic [5:0] ADDR_HI = 6'h22;

	// Special register address bits and control range field position
	localparam int BIT_SYNC = 7;
	localparam int BIT_CLR = 6;
	localparam int CTRL_RANGE_LSB = 2;

	// Output mode that yields light counts
	localparam logic [1:0] OUT_LIGHT = 2'h2;

	// Last oscillator count of an internal integration, per width code
	localparam logic [15:0] LAST_W0 = 16'hFFFF;
	localparam logic [15:0] LAST_W1 = 16'h0FFF;
	localparam logic [15:0] LAST_W2 = 16'h00FF;
	localparam logic [15:0] LAST_W3 = 16'h000F;

	// Operation command register layout, bit 7 first
	typedef struct packed {
		logic core_on;
		logic sleep;
		logic timing_ext;
		logic spare;
		logic [1:0] out_sel;
		logic [1:0] width;
	} lsr_cmd_t;

	// Bus line events seen in the core clock domain
	typedef struct packed {
		logic scl_rise;
		logic scl_fall;
		logic sda;
		logic start;
		logic stop;
	} lsr_line_ev_t;

	typedef enum {
		ST_IDLE, ST_DEV, ST_REG, ST_WR, ST_RD, ST_ACK, ST_MACK
	} lsr_state_t;

endpackage : lsr_pkg

/* lsr_line_sync.sv */
// Bus pin synchroniser with edge, start and stop detection
`timescale 1ns/10ps
module lsr_line_sync (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic addr_select_pin_in,
	output lsr_pkg::lsr_line_ev_t ev_out,
	output logic addr_select_out
);
	logic [1:0] scl_sync_reg;
	logic [1:0] sda_sync_reg;
	logic [1:0] a0_sync_reg;
	logic scl_prev_reg;
	logic sda_prev_reg;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			scl_sync_reg <= 2'h3;
			sda_sync_reg <= 2'h3;
			a0_sync_reg <= 2'h0;
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end else begin
			scl_sync_reg <= {scl_sync_reg[0], scl_in};
			sda_sync_reg <= {sda_sync_reg[0], sda_in};
			a0_sync_reg <= {a0_sync_reg[0], addr_select_pin_in};
			scl_prev_reg <= scl_sync_reg[1];
			sda_prev_reg <= sda_sync_reg[1];
		end
	end

	// The master alone clocks the bus; we only ever observe it
	always_comb begin
		ev_out.scl_rise = scl_sync_reg[1] && !scl_prev_reg;
		ev_out.scl_fall = !scl_sync_reg[1] && scl_prev_reg;
		ev_out.sda = sda_sync_reg[1];
		// Data falling with clock high opens a transaction
		ev_out.start = scl_sync_reg[1] && scl_prev_reg &&
			sda_prev_reg && !sda_sync_reg[1];
		// Data rising with clock high closes it
		ev_out.stop = scl_sync_reg[1] && scl_prev_reg &&
			!sda_prev_reg && sda_sync_reg[1];
	end

	assign addr_select_out = a0_sync_reg[1];

endmodule : lsr_line_sync

/* lsr_integrator.sv */
// Integration timing, cycle counter and result latching
`timescale 1ns/10ps
module lsr_integrator (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic osc_clk_in,
	input lsr_pkg::lsr_cmd_t cmd_in,
	input wire logic sync_in,
	input wire logic [15:0] light_sample_in,
	output logic [15:0] light_count_out,
	output logic [15:0] cycle_count_out,
	output logic done_out
);
	logic [1:0] osc_sync_reg;
	logic osc_prev_reg;
	logic [15:0] tick_cnt_reg;
	logic [15:0] last;
	logic tick;
	logic active;
	logic finish;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			osc_sync_reg <= 2'h0;
			osc_prev_reg <= 1'b0;
		end else begin
			osc_sync_reg <= {osc_sync_reg[0], osc_clk_in};
			osc_prev_reg <= osc_sync_reg[1];
		end
	end

	assign tick = osc_sync_reg[1] && !osc_prev_reg;
	// Reset mode, sleep or a disabling output mode stop the core
	assign active = cmd_in.core_on && !cmd_in.sleep &&
		(cmd_in.out_sel == lsr_pkg::OUT_LIGHT);

	always_comb begin
		unique case (cmd_in.width)
			2'h0: last = lsr_pkg::LAST_W0;
			2'h1: last = lsr_pkg::LAST_W1;
			2'h2: last = lsr_pkg::LAST_W2;
			2'h3: last = lsr_pkg::LAST_W3;
		endcase
	end

	// Host sync ends the period externally, count limit internally
	assign finish = active && (cmd_in.timing_ext ? sync_in :
		(tick && tick_cnt_reg == last));

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tick_cnt_reg <= lsr_pkg::RST_DATA;
		end else if (!active || finish) begin
			tick_cnt_reg <= lsr_pkg::RST_DATA;
		end else if (tick) begin
			tick_cnt_reg <= tick_cnt_reg + 16'h0001;
		end
	end

	// Light result refreshes at each period end, cycles in external mode only; bus writes never reach them
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			light_count_out <= lsr_pkg::RST_DATA;
			cycle_count_out <= lsr_pkg::RST_DATA;
			done_out <= 1'b0;
		end else begin
			done_out <= finish;
			if (finish) begin
				// Scale to signed n-1 bits for the chosen width
				light_count_out <= 16'($signed(light_sample_in) >>>
					{cmd_in.width, 2'h0});
				if (cmd_in.timing_ext)
					cycle_count_out <= tick_cnt_reg;
			end
		end
	end

endmodule : lsr_integrator

/* lsr_bus_master.sv */
// Bus master model: drives the clock, pulls data low when sending 0
`timescale 1ns/10ps
module lsr_bus_master #(
	parameter int HALF = 8
) (
	input wire logic clk_in,
	input wire logic sda_in,
	output logic scl_out,
	output logic sda_oe_out
);
	initial begin
		scl_out = 1'b1;
		sda_oe_out = 1'b0;
	end

	task automatic hold();
		repeat (HALF) @(posedge clk_in);
	endtask : hold

	// Serves as start and repeated start alike
	task automatic start_cond();
		sda_oe_out <= 1'b0;
		hold();
		scl_out <= 1'b1;
		hold();
		sda_oe_out <= 1'b1;
		hold();
		scl_out <= 1'b0;
		hold();
	endtask : start_cond

	task automatic stop_cond();
		sda_oe_out <= 1'b1;
		hold();
		scl_out <= 1'b1;
		hold();
		sda_oe_out <= 1'b0;
		hold();
	endtask : stop_cond

	// Data moves only while the clock is low
	task automatic bit_io(input logic b, output logic r);
		sda_oe_out <= ~b;
		hold();
		scl_out <= 1'b1;
		hold();
		r = sda_in;
		scl_out <= 1'b0;
	endtask : bit_io

	task automatic write_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	endtask : write_byte

	task automatic read_byte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(last, r);
	endtask : read_byte
endmodule : lsr_bus_master

/* lsr_tb.sv */
// Self-checking bench for the light sensor register port
`timescale 1ns/10ps
module testbench;
	logic clk_in, rst_n_in, m_oe, scl, a0, osc, osc_run, ack;
	logic sda_oe_out, sda_out, int_clear_out, conv_done_out;
	logic converter_core_on_out, sleep_request_out;
	logic [1:0] lux_range_out;
	logic [15:0] sample, e;
	logic [7:0] ocnt;
	logic [31:0] seed = 32'hA6C2D68B;
	logic [31:0] v;
	int n_errors = 0, check_count = 0, n_done = 0, n_clr = 0;
	int cyc = 0, gap = 0, last_done = 0, k, nd, nc, per;
	logic [7:0] modes [5] = '{8'h87, 8'h0B, 8'hCB, 8'h8F, 8'h83};
	logic [7:0] regs [7] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h05, 8'h06, 8'h07};
	// Pad drives its data value while enabled, else the pull-up wins
	wire sda = !(m_oe | (sda_oe_out & !sda_out));

	lsr_top dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .scl_in(scl),
		.sda_in(sda), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
		.addr_select_pin_in(a0), .osc_clk_in(osc), .light_sample_in(sample),
		.converter_core_on_out(converter_core_on_out),
		.sleep_request_out(sleep_request_out), .lux_range_out(lux_range_out),
		.int_clear_out(int_clear_out), .conv_done_out(conv_done_out));
	lsr_bus_master m_u (.clk_in(clk_in), .sda_in(sda), .scl_out(scl),
		.sda_oe_out(m_oe));

	initial begin
		clk_in = 1'b0;
		forever #20 clk_in = ~clk_in;
	end

	// One oscillator tick every 8 clocks; stopped ticks give exact counts
	always @(posedge clk_in) begin
		if (!osc_run) begin
			osc <= 1'b0;
			ocnt <= 8'h00;
		end else begin
			ocnt <= ocnt + 8'h01;
			if (ocnt[1:0] == 2'h3)
				osc <= ~osc;
		end
	end

	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (conv_done_out === 1'b1) begin
			n_done <= n_done + 1;
			gap <= cyc - last_done;
			last_done <= cyc;
		end
		if (int_clear_out === 1'b1)
			n_clr <= n_clr + 1;
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	// Light value keeps n-1 signed bits: shift by 16 - n = 4 * code
	function automatic logic [15:0] light_exp(input logic [15:0] s,
		input logic [1:0] w);
		logic signed [15:0] sv;
		sv = $signed(s);
		return sv >>> (4 * w);
	endfunction : light_exp

	task automatic complete_run();
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : complete_run

	task automatic check(input logic [15:0] got, input logic [15:0] exp,
		input string what);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check

	task automatic send(input logic [7:0] d);
		logic a;
		m_u.write_byte(d, a);
		check({15'h0, a}, 16'h0001, "ack");
	endtask : send

	task automatic ptr_wr(input logic [7:0] r, input logic rw_stop);
		m_u.start_cond();
		send({lsr_pkg::ADDR_HI, a0, 1'b0});
		send(r);
		if (rw_stop)
			m_u.stop_cond();
	endtask : ptr_wr

	task automatic reg_wr(input logic [7:0] r, input logic [7:0] d);
		ptr_wr(r, 1'b0);
		send(d);
		m_u.stop_cond();
	endtask : reg_wr

	task automatic rd_chk(input logic [7:0] r, input logic [7:0] x,
		input string what);
		logic [7:0] d;
		ptr_wr(r, 1'b0);
		m_u.start_cond();
		send({lsr_pkg::ADDR_HI, a0, 1'b1});
		m_u.read_byte(1'b1, d);
		m_u.stop_cond();
		check({8'h00, d}, {8'h00, x}, what);
	endtask : rd_chk

	task automatic wait_done(input int cnt);
		int base;
		base = n_done;
		for (int i = 0; i < 40000 && n_done < base + cnt; i++)
			@(posedge clk_in);
		if (n_done < base + cnt) begin
			n_errors++;
			$display("MISMATCH t=%0t no period end", $time);
			complete_run();
		end
	endtask : wait_done

	initial begin
		rst_n_in = 1'b0;
		a0 = 1'b0;
		osc_run = 1'b0;
		sample = 16'h0000;
		repeat (16) @(posedge clk_in);
		rst_n_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		foreach (regs[i]) rd_chk(regs[i], 8'h00, "reset");
		for (int j = 0; j < 2; j++) begin
			a0 <= j[0];
			repeat (4) @(posedge clk_in);
			v = rnd();
			reg_wr(lsr_pkg::OFF_CMD, v[7:0]);
			rd_chk(lsr_pkg::OFF_CMD, v[7:0], "command");
			check({14'h0, converter_core_on_out, sleep_request_out},
				{14'h0, v[7:6]}, "cmd outs");
			reg_wr(lsr_pkg::OFF_CTRL, v[15:8]);
			rd_chk(lsr_pkg::OFF_CTRL, v[15:8] & 8'h0C, "control");
			check({14'h0, lux_range_out}, {14'h0, v[11:10]}, "range");
			m_u.start_cond();
			m_u.write_byte({lsr_pkg::ADDR_HI ^ {j[0], 5'h00}, ~a0, 1'b0}, ack);
			m_u.stop_cond();
			check({15'h0, ack}, 16'h0000, "foreign addr");
		end
		reg_wr(lsr_pkg::OFF_LIGHT_LO, 8'h5A);
		rd_chk(lsr_pkg::OFF_LIGHT_LO, 8'h00, "read-only");
		osc_run <= 1'b1;
		for (int w = 3; w >= 2; w--) begin
			v = rnd();
			sample <= v[15:0];
			reg_wr(lsr_pkg::OFF_CMD, 8'h88 | 8'(w));
			wait_done(2);
			per = 8 << (16 - 4 * w);
			check({15'h0, gap >= per - 1 && gap <= per + 1}, 16'h1, "period");
			e = light_exp(v[15:0], w[1:0]);
			rd_chk(lsr_pkg::OFF_LIGHT_LO, e[7:0], "light lo");
			rd_chk(lsr_pkg::OFF_LIGHT_HI, e[15:8], "light hi");
		end
		foreach (modes[i]) begin
			reg_wr(lsr_pkg::OFF_CMD, modes[i]);
			nd = n_done;
			repeat (400) @(posedge clk_in);
			check(16'(n_done - nd), 16'h0, "idle mode");
		end
		osc_run <= 1'b0;
		v = rnd();
		sample <= v[31:16];
		reg_wr(lsr_pkg::OFF_CMD, 8'hAA);
		ptr_wr(8'h80, 1'b1);
		k = 5 + int'(v[5:0]);
		osc_run <= 1'b1;
		repeat (8 * k) @(posedge clk_in);
		osc_run <= 1'b0;
		nd = n_done;
		nc = n_clr;
		ptr_wr(8'hC0, 1'b1);
		repeat (8) @(posedge clk_in);
		check(16'(n_done - nd), 16'h1, "restart end");
		check(16'(n_clr - nc), 16'h1, "int clear");
		rd_chk(lsr_pkg::OFF_CYC_LO, k[7:0], "cycles lo");
		rd_chk(lsr_pkg::OFF_CYC_HI, 8'h00, "cycles hi");
		e = light_exp(v[31:16], 2'h2);
		rd_chk(lsr_pkg::OFF_LIGHT_LO, e[7:0], "ext light");
		reg_wr(lsr_pkg::OFF_CMD, 8'h8B);
		nd = n_done;
		ptr_wr(8'h80, 1'b1);
		repeat (8) @(posedge clk_in);
		check(16'(n_done - nd), 16'h0, "internal restart");
		complete_run();
	end
endmodule : testbench
